//--- design/dcp_pkg.sv
// dcp_pkg: constants shared by the clock-phase delay-lock loop and its delay line.
// assumes: one 250 MHz clock, registers reached through the serial register port.
package dcp_pkg;

    // ----------------------------------------------------------------
    // widths and delay line limits
    // ----------------------------------------------------------------
    localparam int          CODE_W      = 9;
    localparam int          REQ_W       = 11;
    localparam int          PH_W        = 5;
    localparam logic [8:0]  CODE_MAX    = 9'h1b0;   // 432 taps, about 2 ps each
    localparam logic [8:0]  CODE_RST    = 9'h0d8;   // midpoint start code
    localparam int          GUARD_SHIFT = 3;        // one guard unit is eight taps

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0]  A_PWR   = 8'h01;
    localparam logic [7:0]  A_PDET  = 8'h24;
    localparam logic [7:0]  A_SLOPE = 8'h25;
    localparam logic [7:0]  A_CTRL  = 8'h26;
    localparam logic [7:0]  A_PHASE = 8'h27;
    localparam logic [7:0]  A_DEL   = 8'h28;
    localparam logic [7:0]  A_GUARD = 8'h29;
    localparam logic [7:0]  A_STAT  = 8'h2a;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int PWR_CLK_BIT     = 5;
    localparam int PWR_RX_BIT      = 4;
    localparam int SLOPE_NEG_BIT   = 7;
    localparam int CTRL_EN_BIT     = 0;
    localparam int CTRL_GAIN_BIT   = 1;
    localparam int CTRL_RD_BIT     = 3;
    localparam int PH_DEL0_BIT     = 7;
    localparam int CFG_RETRY_BIT   = 6;
    localparam int CFG_RESTART_BIT = 5;
    localparam int ST_LKD_BIT      = 0;
    localparam int ST_LST_BIT      = 1;

    localparam logic [7:0] REG_RST = 8'h00;

    // ----------------------------------------------------------------
    // lock thresholds and timing
    // ----------------------------------------------------------------
    localparam logic [4:0] ERR_LOSE = 5'h04;    // lock drops above this
    localparam logic [4:0] ERR_GAIN = 5'h03;    // lock returns at or below this
    localparam int CLK_NS      = 4;
    localparam int SETTLE_NS   = 40;
    localparam int TRACK_NS    = 200;
    localparam int SETTLE_CYC  = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int TRACK_CYC   = (TRACK_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W       = 8;

    typedef enum logic [2:0] {ST_IDLE, ST_SEARCH, ST_SLOPE, ST_TRACK, ST_FAIL} dcp_state_e;

endpackage

//--- design/dcp_tap_if.sv
// dcp_tap_if: request and applied code between the loop controller and the delay line.
// assumes: both ends on the same clock.
`timescale 1ns/100ps
interface dcp_tap_if;
    import dcp_pkg::*;
    logic signed [REQ_W-1:0]  req_code;
    logic                     req_valid;
    logic        [CODE_W-1:0] code;
    logic                     clipped;

    modport ctrl (output req_code, output req_valid, input code, input clipped);
    modport line (input req_code, input req_valid, output code, output clipped);
endinterface

//--- design/dcp_delay_line.sv
// dcp_delay_line: holds the tap select of the digital clock delay line.
// assumes: requests may lie outside the line; they are clamped here.
`timescale 1ns/100ps
module dcp_delay_line
    import dcp_pkg::*;
(
    input  wire logic  mclk_i,
    input  wire logic  rst_n,
    dcp_tap_if.line    tap
);
    import dcp_pkg::*;

    localparam logic signed [REQ_W-1:0] MAX_S = REQ_W'(signed'({2'b00, CODE_MAX}));

    // clipped holds until the next request, so the tracker still sees it at its next step
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            tap.code    <= CODE_RST;
            tap.clipped <= 1'b0;
        end else if (tap.req_valid) begin
            if (tap.req_code < 0) begin
                tap.code    <= '0;
                tap.clipped <= 1'b1;
            end else if (tap.req_code > MAX_S) begin
                tap.code    <= CODE_MAX;
                tap.clipped <= 1'b1;
            end else begin
                tap.code    <= tap.req_code[CODE_W-1:0];
                tap.clipped <= 1'b0;
            end
        end
    end
endmodule

//--- design/dcp_dll.sv
// dcp_dll: delay-lock loop that aligns the digital clock to the analog sampling clock,
// plus power-down control of the clock output driver and the data receivers.
// assumes: phase detector result arrives asynchronously; register port is synchronous.
`timescale 1ns/100ps
module dcp_dll
    import dcp_pkg::*;
#(
    parameter int RX_W = 14
) (
    input  wire logic                   mclk_i,
    input  wire logic                   rstn_i,
    input  wire logic                   reg_we_i,
    input  wire logic                   reg_re_i,
    input  wire logic [7:0]             reg_addr_i,
    input  wire logic [7:0]             reg_wdata_i,
    output logic      [7:0]             reg_rdata_o,
    input  wire logic [dcp_pkg::PH_W-1:0] phase_i,
    input  wire logic [RX_W-1:0]        rx_p_i,
    input  wire logic [RX_W-1:0]        rx_n_i,
    output logic      [RX_W-1:0]        rx_data_o,
    output logic                        rx_en_o,
    output logic                        data_clock_output_en_o,
    output logic      [dcp_pkg::CODE_W-1:0] delay_code_o
);
    import dcp_pkg::*;

    // ----------------------------------------------------------------
    // reset release and input synchronisers
    // ----------------------------------------------------------------
    logic             rst_s1_ff, rst_n;
    logic [PH_W-1:0]  ph_s1_ff, ph_s2_ff, ph_s3_ff, ph_ff;
    logic [RX_W-1:0]  rx_s1_ff, rx_s2_ff, rx_s3_ff;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_s1_ff <= 1'b0;
            rst_n     <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_n     <= rst_s1_ff;
        end
    end

    // a multi-bit phase word is only taken once two stages agree, so a word caught mid-change is dropped
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            ph_s1_ff <= '0;
            ph_s2_ff <= '0;
            ph_s3_ff <= '0;
            ph_ff    <= '0;
        end else begin
            ph_s1_ff <= phase_i;
            ph_s2_ff <= ph_s1_ff;
            ph_s3_ff <= ph_s2_ff;
            if (ph_s2_ff == ph_s3_ff)
                ph_ff <= ph_s3_ff;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0]        pwr_ff, pdet_ff, slope_ff, ctrl_ff, guard_ff;
    logic [PH_W-1:0]   target_ff;
    logic [CODE_W-1:0] init_ff;
    logic              start_ff, lkd_ff, lst_ff;
    dcp_state_e        state_ff;

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            pwr_ff    <= REG_RST;
            pdet_ff   <= REG_RST;
            slope_ff  <= REG_RST;
            ctrl_ff   <= REG_RST;
            guard_ff  <= REG_RST;
            target_ff <= '0;
            init_ff   <= CODE_RST;
            start_ff  <= 1'b0;
        end else begin
            start_ff <= reg_we_i && reg_addr_i == A_CTRL && reg_wdata_i[CTRL_EN_BIT];
            if (reg_we_i) begin
                case (reg_addr_i)
                    A_PWR:   pwr_ff   <= reg_wdata_i;
                    A_PDET:  pdet_ff  <= reg_wdata_i;
                    A_SLOPE: slope_ff <= reg_wdata_i;
                    A_CTRL:  ctrl_ff  <= reg_wdata_i;
                    A_GUARD: guard_ff <= reg_wdata_i;
                    A_PHASE: begin
                        target_ff  <= reg_wdata_i[PH_W-1:0];
                        init_ff[0] <= reg_wdata_i[PH_DEL0_BIT];
                    end
                    A_DEL:   init_ff[CODE_W-1:1] <= reg_wdata_i;
                    default: ;
                endcase
            end
        end
    end

    dcp_tap_if tap ();

    // read bit selects the code in use rather than the programmed start code
    logic [CODE_W-1:0] rd_code;
    assign rd_code = ctrl_ff[CTRL_RD_BIT] ? tap.code : init_ff;

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_o <= '0;
        end else if (reg_re_i) begin
            case (reg_addr_i)
                A_PWR:   reg_rdata_o <= pwr_ff;
                A_PDET:  reg_rdata_o <= pdet_ff;
                A_SLOPE: reg_rdata_o <= slope_ff;
                A_CTRL:  reg_rdata_o <= ctrl_ff;
                A_GUARD: reg_rdata_o <= guard_ff;
                A_PHASE: reg_rdata_o <= {rd_code[0], 2'b00, (ctrl_ff[CTRL_RD_BIT] ? ph_ff : target_ff)};
                A_DEL:   reg_rdata_o <= rd_code[CODE_W-1:1];
                A_STAT:  reg_rdata_o <= {6'h00, lst_ff, lkd_ff};
                default: reg_rdata_o <= '0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // power-down and receivers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            data_clock_output_en_o <= 1'b0;
            rx_en_o                <= 1'b0;
        end else begin
            data_clock_output_en_o <= !pwr_ff[PWR_CLK_BIT];
            rx_en_o                <= !pwr_ff[PWR_RX_BIT];
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            rx_s1_ff  <= '0;
            rx_s2_ff  <= '0;
            rx_s3_ff  <= '0;
            rx_data_o <= '0;
        end else begin
            rx_s1_ff <= pwr_ff[PWR_RX_BIT] ? '0 : (rx_p_i & ~rx_n_i);
            rx_s2_ff <= rx_s1_ff;
            rx_s3_ff <= rx_s2_ff;
            for (int i = 0; i < RX_W; i++)
                if (rx_s2_ff[i] == rx_s3_ff[i])
                    rx_data_o[i] <= rx_s3_ff[i];
        end
    end

    // ----------------------------------------------------------------
    // loop controller
    // ----------------------------------------------------------------
    function automatic logic [PH_W-1:0] mag(input logic signed [PH_W-1:0] v);
        mag = v[PH_W-1] ? PH_W'(-v) : v;
    endfunction

    function automatic logic signed [REQ_W-1:0] ext(input logic [CODE_W-1:0] c);
        ext = REQ_W'(signed'({2'b00, c}));
    endfunction

    logic signed [PH_W-1:0]  err;
    logic signed [PH_W-1:0]  ph_base_ff;
    logic        [CNT_W-1:0] wait_ff;
    logic        [CODE_W-1:0] k_ff;
    logic                    dir_ff, up_done_ff, dn_done_ff, wide_ff, pend_ff;
    logic signed [REQ_W-1:0] lim_lo, lim_hi, cand, step;
    logic                    cand_ok;

    assign err    = PH_W'(signed'(ph_ff - target_ff));   // wraps on the 32-step circle
    assign lim_lo = wide_ff ? '0 : REQ_W'(signed'({3'b000, guard_ff[4:0], 3'b000}));
    assign lim_hi = wide_ff ? ext(CODE_MAX) : ext(CODE_MAX) - REQ_W'(signed'({3'b000, guard_ff[4:0], 3'b000}));
    assign cand   = dir_ff ? ext(init_ff) - ext(k_ff) : ext(init_ff) + ext(k_ff);
    assign cand_ok = (cand >= lim_lo) && (cand <= lim_hi);
    assign step   = ctrl_ff[CTRL_GAIN_BIT] ? REQ_W'(2) : REQ_W'(1);
    assign delay_code_o = tap.code;

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;  wait_ff <= '0;  k_ff <= '0;  dir_ff <= 1'b0;
            up_done_ff <= 1'b0;  dn_done_ff <= 1'b0;  wide_ff <= 1'b0;  pend_ff <= 1'b0;
            ph_base_ff <= '0;  tap.req_valid <= 1'b0;  tap.req_code <= '0;
        end else begin
            tap.req_valid <= 1'b0;
            if (wait_ff != '0)
                wait_ff <= wait_ff - 1'b1;
            if (start_ff || !ctrl_ff[CTRL_EN_BIT]) begin
                state_ff <= start_ff ? ST_SEARCH : ST_IDLE;
                k_ff <= '0;  dir_ff <= 1'b0;  up_done_ff <= 1'b0;  dn_done_ff <= 1'b0;
                wide_ff <= 1'b0;  pend_ff <= 1'b1;  wait_ff <= CNT_W'(SETTLE_CYC);
                tap.req_valid <= start_ff;
                tap.req_code  <= ext(init_ff);
            end else if (wait_ff == '0) begin
                case (state_ff)
                    ST_SEARCH: begin
                        if (pend_ff && err == '0) begin
                            ph_base_ff    <= signed'(ph_ff);
                            tap.req_valid <= 1'b1;
                            tap.req_code  <= ext(tap.code) + REQ_W'(1);
                            wait_ff       <= CNT_W'(SETTLE_CYC);
                            state_ff      <= ST_SLOPE;
                        end else if (up_done_ff && dn_done_ff) begin
                            if (!wide_ff) begin
                                wide_ff <= 1'b1;  up_done_ff <= 1'b0;  dn_done_ff <= 1'b0;
                            end else if (guard_ff[CFG_RETRY_BIT]) begin
                                wide_ff <= 1'b0;  up_done_ff <= 1'b0;  dn_done_ff <= 1'b0;
                            end else begin
                                state_ff <= ST_FAIL;
                            end
                            k_ff <= '0;  dir_ff <= 1'b0;  pend_ff <= 1'b0;
                        end else begin
                            if (cand_ok && !(dir_ff ? dn_done_ff : up_done_ff)) begin
                                tap.req_valid <= 1'b1;
                                tap.req_code  <= cand;
                                wait_ff       <= CNT_W'(SETTLE_CYC);
                                pend_ff       <= 1'b1;
                            end else begin
                                pend_ff <= 1'b0;
                                if (dir_ff)
                                    dn_done_ff <= 1'b1;
                                else
                                    up_done_ff <= 1'b1;
                            end
                            dir_ff <= !dir_ff;
                            if (dir_ff)
                                k_ff <= k_ff + 1'b1;
                        end
                    end
                    ST_SLOPE: begin
                        // phase falling with more delay means a negative slope
                        if ((PH_W'(signed'(ph_ff) - ph_base_ff) > 0 && ph_ff != ph_base_ff)
                                == !slope_ff[SLOPE_NEG_BIT] && ph_ff != ph_base_ff) begin
                            state_ff <= ST_TRACK;
                            wait_ff  <= CNT_W'(TRACK_CYC);
                        end else begin
                            state_ff <= ST_SEARCH;
                            pend_ff  <= 1'b0;
                        end
                    end
                    ST_TRACK: begin
                        wait_ff <= CNT_W'(TRACK_CYC);
                        if (tap.clipped && guard_ff[CFG_RESTART_BIT]) begin
                            state_ff <= ST_SEARCH;
                            k_ff <= '0;  dir_ff <= 1'b0;  up_done_ff <= 1'b0;  dn_done_ff <= 1'b0;
                            pend_ff <= 1'b0;  wait_ff <= '0;
                        end else if (err != '0) begin
                            tap.req_valid <= 1'b1;
                            tap.req_code  <= ((err > 0) == slope_ff[SLOPE_NEG_BIT]) ?
                                             ext(tap.code) + step : ext(tap.code) - step;
                        end
                    end
                    ST_IDLE, ST_FAIL: ;
                    default: state_ff <= ST_IDLE;
                endcase
            end
        end
    end

    // lost sets only from a held lock, clears only on relock or a new start
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            lkd_ff <= 1'b0;
            lst_ff <= 1'b0;
        end else if (start_ff) begin
            lkd_ff <= 1'b0;
            lst_ff <= 1'b0;
        end else if (state_ff == ST_TRACK) begin
            if (mag(err) > ERR_LOSE) begin
                lkd_ff <= 1'b0;
                if (lkd_ff)
                    lst_ff <= 1'b1;
            end else if (mag(err) <= ERR_GAIN) begin
                lkd_ff <= 1'b1;
                lst_ff <= 1'b0;
            end
        end
    end

    dcp_delay_line i_dcp_delay_line (
        .mclk_i (mclk_i),
        .rst_n  (rst_n),
        .tap    (tap.line)
    );
endmodule

//--- test/dcp_dll_asserts.sv
// dcp_dll_asserts: port-level checks for the clock-phase loop top.
// assumes: bound to dcp_dll; register strobes are single-cycle pulses.
`timescale 1ns/100ps
module dcp_dll_asserts
    import dcp_pkg::*;
#(
    parameter int RX_W = 14
) (
    input wire logic              mclk_i,
    input wire logic              rstn_i,
    input wire logic              reg_we_i,
    input wire logic              reg_re_i,
    input wire logic [7:0]        reg_addr_i,
    input wire logic [7:0]        reg_wdata_i,
    input wire logic [7:0]        reg_rdata_o,
    input wire logic [PH_W-1:0]   phase_i,
    input wire logic [RX_W-1:0]   rx_p_i,
    input wire logic [RX_W-1:0]   rx_n_i,
    input wire logic [RX_W-1:0]   rx_data_o,
    input wire logic              rx_en_o,
    input wire logic              data_clock_output_en_o,
    input wire logic [CODE_W-1:0] delay_code_o
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    logic       on_ff;
    logic [1:0] idle_ff;
    logic       pwr_wr;
    logic       unmapped;
    assign pwr_wr   = reg_we_i && (reg_addr_i == A_PWR);
    assign unmapped = !(reg_addr_i == A_PWR || (reg_addr_i >= A_PDET && reg_addr_i <= A_STAT));

    // a stopped loop may still land one pending request, so wait three cycles
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            on_ff   <= 1'b0;
            idle_ff <= 2'h3;
        end else if (reg_we_i && reg_addr_i == A_CTRL) begin
            on_ff   <= reg_wdata_i[CTRL_EN_BIT];
            idle_ff <= 2'h0;
        end else if (!on_ff && idle_ff != 2'h3) begin
            idle_ff <= idle_ff + 2'h1;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    code_range_a: assert property (delay_code_o <= CODE_MAX)
        else $error("delay code beyond last tap");
    clk_off_a: assert property (pwr_wr && reg_wdata_i[PWR_CLK_BIT] |-> ##[1:3] !data_clock_output_en_o)
        else $error("clock driver not powered down");
    clk_on_a: assert property (pwr_wr && !reg_wdata_i[PWR_CLK_BIT] |-> ##[1:3] data_clock_output_en_o)
        else $error("clock driver not powered up");
    rx_off_a: assert property (pwr_wr && reg_wdata_i[PWR_RX_BIT] |-> ##[1:3] !rx_en_o)
        else $error("receivers not powered down");
    rx_on_a: assert property (pwr_wr && !reg_wdata_i[PWR_RX_BIT] |-> ##[1:3] rx_en_o)
        else $error("receivers not powered up");
    rx_quiet_a: assert property (!rx_en_o [*5] |-> rx_data_o == '0)
        else $error("receiver data moves while powered down");
    rx_level_a: assert property ((rx_en_o && $stable(rx_p_i) && $stable(rx_n_i)) [*6]
        |-> rx_data_o == (rx_p_i & ~rx_n_i))
        else $error("receiver data does not follow input polarity");
    pwr_readback_a: assert property (reg_re_i && reg_addr_i == A_PWR && !$past(reg_we_i)
        |=> reg_rdata_o[5] != data_clock_output_en_o && reg_rdata_o[4] != rx_en_o)
        else $error("power register and enables disagree");
    unmapped_rd_a: assert property (reg_re_i && unmapped |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    idle_hold_a: assert property (!on_ff && idle_ff == 2'h3 |-> $stable(delay_code_o))
        else $error("delay code moved with loop idle");

    cover property (pwr_wr && reg_wdata_i[PWR_CLK_BIT]);
    cover property (reg_re_i && reg_addr_i == A_STAT);
    cover property (on_ff && delay_code_o != CODE_RST);
endmodule

bind dcp_dll dcp_dll_asserts #(.RX_W(RX_W)) i_dcp_dll_asserts (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .phase_i(phase_i), .rx_p_i(rx_p_i), .rx_n_i(rx_n_i), .rx_data_o(rx_data_o), .rx_en_o(rx_en_o),
    .data_clock_output_en_o(data_clock_output_en_o), .delay_code_o(delay_code_o));

//--- test/dcp_phase_model.sv
// dcp_phase_model: stand-in for the analog/digital clock phase detector.
// assumes: 32 taps span one clock period, so the word advances one per tap.
`timescale 1ns/100ps
module dcp_phase_model (
    input  wire logic [8:0] code_i,
    input  wire logic [4:0] skew_i,
    output logic      [4:0] phase_o
);
    // full 5-bit wrap is one period, so 16 reads as half a period
    // skew_i stands in for drift between the two clock paths
    assign #1 phase_o = code_i[4:0] + skew_i;
endmodule

//--- test/dcp_dll_tb.sv
// dcp_dll_tb: self-checking bench for the clock-phase loop top.
// assumes: phase word modelled from the applied code; reads checked from a queue.
`timescale 1ns/100ps
module dcp_dll_tb;
    import dcp_pkg::*;
    localparam int RX_W = 14;
    logic              mclk_i = 1'b0;
    logic              rstn_i = 1'b0;
    logic              reg_we_i = 1'b0;
    logic              reg_re_i = 1'b0;
    logic [7:0]        reg_addr_i = 8'h00;
    logic [7:0]        reg_wdata_i = 8'h00;
    logic [7:0]        reg_rdata_o;
    logic [PH_W-1:0]   phase_i;
    logic [4:0]        skew = 5'h00;
    logic [RX_W-1:0]   rx_p_i = '0;
    logic [RX_W-1:0]   rx_n_i = '1;
    logic [RX_W-1:0]   rx_data_o;
    logic              rx_en_o;
    logic              clk_out_en;
    logic [CODE_W-1:0] delay_code_o;
    logic [7:0]        exp_q[$];
    logic [7:0]        v;
    logic [7:0]        rw_tab[5] = '{A_PDET, A_SLOPE, A_PHASE, A_DEL, A_GUARD};
    int                n_errors = 0;
    int                checks = 0;
    int                seed = 32'h928c;

    dcp_dll #(.RX_W(RX_W)) i_dcp_dll (.mclk_i(mclk_i), .rstn_i(rstn_i), .reg_we_i(reg_we_i),
        .reg_re_i(reg_re_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .phase_i(phase_i), .rx_p_i(rx_p_i), .rx_n_i(rx_n_i),
        .rx_data_o(rx_data_o), .rx_en_o(rx_en_o), .data_clock_output_en_o(clk_out_en),
        .delay_code_o(delay_code_o));
    dcp_phase_model i_dcp_phase_model (.code_i(delay_code_o), .skew_i(skew), .phase_o(phase_i));

    initial begin
        forever #2 mclk_i = ~mclk_i;
    end

    // ----------------------------------------------------------------
    // bus tasks and checking
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        reg_we_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(negedge mclk_i);
        reg_we_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge mclk_i);
        reg_re_i <= 1'b1;
        reg_addr_i <= a;
        exp_q.push_back(e);
        @(negedge mclk_i);
        reg_re_i <= 1'b0;
    endtask

    // read data stands from the edge that took the strobe
    always @(negedge mclk_i) begin
        if (reg_re_i === 1'b1) begin
            chk(reg_rdata_o, exp_q.pop_front());
        end
    end

    task automatic wait_code(input int lo, input int hi, input int lim);
        int k;
        for (k = 0; k < lim && !(delay_code_o >= lo && delay_code_o <= hi); k++) @(negedge mclk_i);
        chk(delay_code_o >= lo && delay_code_o <= hi, 16'h1);
    endtask

    task automatic wrap_up;
        $display("checks %0d, errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        #100000;
        n_errors++;
        wrap_up();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (6) @(negedge mclk_i);
        rstn_i <= 1'b1;
        repeat (4) @(negedge mclk_i);
        chk(delay_code_o, CODE_RST);
        chk({clk_out_en, rx_en_o}, 2'b11);
        for (int i = 0; i < 8; i++) begin
            v = {2'b00, i[1:0], 4'h0};
            rx_p_i <= RX_W'($random(seed));
            rx_n_i <= RX_W'($random(seed));
            wr(A_PWR, v);
            repeat (6) @(negedge mclk_i);
            chk({clk_out_en, rx_en_o}, {~v[5], ~v[4]});
            chk(rx_data_o, v[4] ? '0 : rx_p_i & ~rx_n_i);
            rd(A_PWR, v);
        end
        foreach (rw_tab[k]) begin
            v = 8'($random(seed));
            wr(rw_tab[k], v);
            // bits 6:5 of the phase register are not kept and read as zero
            rd(rw_tab[k], rw_tab[k] == A_PHASE ? v & 8'h9f : v);
        end
        wr(8'h50, 8'hff);
        rd(8'h50, 8'h00);
        wr(A_STAT, 8'hff);
        rd(A_STAT, 8'h00);
        // slope is positive in this phase model, so the target sits 14 taps up
        wr(A_PDET, 8'h30);
        wr(A_SLOPE, 8'h00);
        wr(A_PHASE, 8'h06);
        wr(A_DEL, 8'h6c);
        wr(A_GUARD, 8'hcb);
        wr(A_CTRL, 8'h03);
        wait_code(229, 231, 3000);
        repeat (150) @(negedge mclk_i);
        wait_code(229, 231, 1);
        rd(A_STAT, 8'h01);
        skew <= 5'h02;
        wait_code(227, 229, 400);
        repeat (150) @(negedge mclk_i);
        wait_code(227, 229, 1);
        rd(A_STAT, 8'h01);
        skew <= 5'h0c;
        repeat (60) @(negedge mclk_i);
        rd(A_STAT, 8'h02);
        wait_code(215, 221, 1000);
        repeat (100) @(negedge mclk_i);
        rd(A_STAT, 8'h01);
        // start one tap past the line end: the request must clamp, and no slope can ever be confirmed
        wr(A_PHASE, 8'h9c);
        wr(A_DEL, 8'hd8);
        wr(A_CTRL, 8'h0b);
        wait_code(432, 432, 40);
        repeat (60) @(negedge mclk_i);
        wait_code(432, 432, 1);
        rd(A_PHASE, 8'h1c);
        rd(A_DEL, 8'hd8);
        rd(A_STAT, 8'h00);
        wr(A_CTRL, 8'h00);
        repeat (10) @(negedge mclk_i);
        wait_code(432, 432, 1);
        rd(A_PHASE, 8'h9c);
        repeat (2) @(negedge mclk_i);
        wrap_up();
    end
endmodule
